// >>> tcp_top.sv
/*
  tcp_top: temperature channel protection with APB registers.
  assumes: temperatures arrive as one-cycle update strobes with a
  channel index, synchronous to CLK; APB master in the CLK domain.
*/
// The placing of the registers and the APB slave port were left to the implementer.
// Overview of operation
// [R1] channel trip immediately above trip threshold
// [R2] per-channel delayed alarm, individually enabled
// [R3] trip and alarm drop out at 0.99
// [R4] global and per-channel on/off switches
// [R5] winding six, ambient two, auxiliary four
// [R6] group uses hottest active member channel
// [R7] vote scheme inert unless function set
// [R8] vote trip when count reaches setting
// [R9] vote needs selected, active channel, function
// [R10] voting forwarded only when source is voting
// [R11] group flags OR of member flags
// [R12] any-group outputs OR over all groups
// [R13] group timeout when any member times out
// [R14] collective timeout ORs sensors and groups
// [R15] final trip source selects default or voting
// [R16] blocking input suppresses all trip outputs
// [R17] alarm timer restarts on dropout
// [R18] channel timeout without update in interval
`timescale 1ns/100ps
module tcp_top
  import tcp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TEMP_UPD,
  input wire logic [CH_W-1:0] TEMP_CH,
  input wire logic [TEMP_W-1:0] TEMP_VAL,
  input wire logic BLOCK_TRIP,
  output logic [NCH-1:0] CHAN_TRIP,
  output logic [NCH-1:0] CHAN_ALARM,
  output logic [NCH-1:0] CHAN_TIMEOUT,
  output logic ALARM_ANY,
  output logic TRIP_ANY,
  output logic TIMEOUT_ANY,
  output logic TIMEOUT_ALARM,
  output logic [NVOTE-1:0] VOTE_TRIP,
  output logic FINAL_TRIP,
  output logic IRQ
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // whole module state
  typedef struct packed {
    logic fn_on;
    tcp_src_t src;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [TO_W-1:0] tolim;
    logic [NVOTE-1:0][31:0] vote;
    logic [NELEM-1:0][31:0] cfg;
    logic [NCH-1:0][TEMP_W-1:0] temp;
    logic [NCH-1:0][TO_W-1:0] tocnt;
    logic [TICK_W-1:0] pre;
    logic tick;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NCH-1:0] chtrip;
    logic [NCH-1:0] chalm;
    logic [NCH-1:0] chto;
    logic alm_any;
    logic trip_any;
    logic to_any;
    logic to_all;
    logic [NVOTE-1:0] vtrip;
    logic final_trip;
    logic irq;
  } tcp_state_t;
  tcp_state_t s_r, s_nxt;

  logic [NCH-1:0] ch_act; // channel switched on and function on
  logic [NGRP-1:0] grp_act; // group element on with an active member
  logic [NGRP-1:0][TEMP_W-1:0] grp_temp; // hottest active member
  logic [NELEM-1:0] e_en; // element enables
  logic [NELEM-1:0][TEMP_W-1:0] e_temp; // element temperatures
  logic [NELEM-1:0] e_trip; // raw element trips
  logic [NELEM-1:0] e_alm; // element alarms
  logic [NVOTE-1:0] v_trip; // scheme trips
  logic [NGRP-1:0] g_alm; // group alarms
  logic [NGRP-1:0] g_trip; // group trips
  logic [NGRP-1:0] g_to; // group timeouts
  logic [2:0] ev; // interrupt events
  logic [2:0] w1c; // status clear bits
  logic [31:0] rd; // read mux
  logic hit; // mapped address
  logic wr; // write strobe

  // address inside the element config window
  function automatic logic cfg_hit(input logic [7:0] a);
    cfg_hit = (a >= CFG_BASE) && (a < CFG_END) && (a[1:0] == 2'h0);
  endfunction

  // element index of a config address
  function automatic logic [CH_W-1:0] cfg_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - CFG_BASE;
    cfg_idx = d[CH_W+1:2];
  endfunction

  // hottest temperature among flagged channels
  function automatic logic [TEMP_W-1:0] max_of(input logic [NCH-1:0][TEMP_W-1:0] t,
                                                 input logic [NCH-1:0] m);
    max_of = '0;
    for (int i = 0; i < NCH; i++) begin
      if (m[i] && t[i] > max_of) begin
        max_of = t[i];
      end
    end
  endfunction

  // activity and group temperatures
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // [R4] global and channel switch
      ch_act[i] = s_r.fn_on && s_r.cfg[i][CFG_ON];
      e_en[i] = ch_act[i];
      e_temp[i] = s_r.temp[i];
    end
    for (int g = 0; g < NGRP; g++) begin
      // [R5] fixed group membership
      // [R6] hottest active member
      // zero when no member is active, so an idle group never picks up
      grp_temp[g] = max_of(s_r.temp, ch_act & GRP_MASK[g]);
      grp_act[g] = s_r.fn_on && s_r.cfg[NCH + g][CFG_ON] && (|(ch_act & GRP_MASK[g]));
      e_en[NCH + g] = grp_act[g];
      e_temp[NCH + g] = grp_temp[g];
    end
  end

  // threshold elements, channels then groups
  for (genvar k = 0; k < NELEM; k++) begin : g_elem
    tcp_elem u_elem (
      .clk(CLK),
      .rst_n(RST_N),
      .tick(s_r.tick),
      .en(e_en[k]),
      .alarm_en(s_r.cfg[k][CFG_AEN]),
      .temp(e_temp[k]),
      .trip_thr(s_r.cfg[k][CFG_TRIP_LO +: TEMP_W]),
      .alm_thr(s_r.cfg[k][CFG_ALM_LO +: TEMP_W]),
      .alm_dly(s_r.cfg[k][CFG_DLY_LO +: DLY_W]),
      .trip(e_trip[k]),
      .alarm(e_alm[k])
    );
  end

  // voting schemes
  for (genvar v = 0; v < NVOTE; v++) begin : g_vote
    tcp_vote #(.N(NCH)) u_vote (
      .clk(CLK),
      .rst_n(RST_N),
      .fn_on(s_r.vote[v][VOTE_FN]),
      // [R9] selected, active channel and function
      .sel(s_r.vote[v][VOTE_SEL_LO +: NCH] & ch_act),
      .hit(e_trip[NCH-1:0]),
      .need(s_r.vote[v][VOTE_CNT_LO +: CNT_W]),
      .trip(v_trip[v])
    );
  end

  // group collection
  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      // [R11] group flag from any member
      g_alm[g] = e_alm[NCH + g] || (|(e_alm[NCH-1:0] & GRP_MASK[g]));
      g_trip[g] = e_trip[NCH + g] || (|(e_trip[NCH-1:0] & GRP_MASK[g]));
      // [R13] group timeout from members
      g_to[g] = |(s_r.chto & GRP_MASK[g]);
    end
  end

  // register read mux and decode
  always_comb begin
    rd = 32'h0000_0000;
    hit = 1'b1;
    case (PADDR)
      REG_CTRL: begin
        rd[CTRL_ON] = s_r.fn_on;
        rd[CTRL_SRC] = (s_r.src == SRC_VOTING);
      end
      REG_STATUS: begin
        // flags packed from bit 0 upward, upper bits read zero
        rd = {13'h0000, s_r.final_trip, s_r.vtrip, s_r.to_all, s_r.to_any, s_r.trip_any,
              s_r.alm_any, s_r.chto};
      end
      REG_IRQ_STAT: begin
        rd[2:0] = s_r.stat;
      end
      REG_IRQ_MASK: begin
        rd[2:0] = s_r.mask;
      end
      REG_TO_LIM: begin
        rd[TO_W-1:0] = s_r.tolim;
      end
      REG_VOTE0: begin
        rd = s_r.vote[0];
      end
      REG_VOTE1: begin
        rd = s_r.vote[1];
      end
      default: begin
        if (cfg_hit(PADDR)) begin
          rd = s_r.cfg[cfg_idx(PADDR)];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    // writes land only at the ready edge of a mapped access
    wr = PSEL && PENABLE && PWRITE && s_r.pready && hit;
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    w1c = 3'h0;
    // slow tick prescaler
    s_nxt.tick = 1'b0;
    if (s_r.pre == TICK_W'(TICK_CYCLES - 1)) begin
      s_nxt.pre = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.pre = s_r.pre + 1'b1;
    end
    // temperature capture and supervision
    for (int i = 0; i < NCH; i++) begin
      if (TEMP_UPD && TEMP_CH == CH_W'(i)) begin
        s_nxt.temp[i] = TEMP_VAL;
        s_nxt.tocnt[i] = '0;
      // saturate at the limit; a lowered limit must not let the count wrap
      end else if (s_r.tick && s_r.tocnt[i] < s_r.tolim) begin
        s_nxt.tocnt[i] = s_r.tocnt[i] + 1'b1;
      end
      // [R18] no update within interval
      s_nxt.chto[i] = ch_act[i] && (s_r.tocnt[i] >= s_r.tolim);
    end
    // apb: answer in the first access cycle
    s_nxt.pready = PSEL && !PENABLE;
    if (PSEL && !PENABLE) begin
      s_nxt.prdata = PWRITE ? 32'h0000_0000 : rd;
      s_nxt.pslverr = !hit;
    end
    // register writes
    if (wr) begin
      case (PADDR)
        REG_CTRL: begin
          s_nxt.fn_on = PWDATA[CTRL_ON];
          s_nxt.src = PWDATA[CTRL_SRC] ? SRC_VOTING : SRC_DEFAULT;
        end
        REG_STATUS: begin
          // flags are read only: the write is taken but changes nothing
        end
        REG_IRQ_STAT: begin
          w1c = PWDATA[2:0];
        end
        REG_IRQ_MASK: begin
          s_nxt.mask = PWDATA[2:0];
        end
        REG_TO_LIM: begin
          s_nxt.tolim = PWDATA[TO_W-1:0];
        end
        REG_VOTE0: begin
          s_nxt.vote[0] = PWDATA;
        end
        REG_VOTE1: begin
          s_nxt.vote[1] = PWDATA;
        end
        default: begin
          s_nxt.cfg[cfg_idx(PADDR)] = PWDATA;
        end
      endcase
    end
    // [R16] blocking suppresses trips
    s_nxt.chtrip = BLOCK_TRIP ? '0 : e_trip[NCH-1:0];
    s_nxt.chalm = e_alm[NCH-1:0];
    // [R12] any-group collectors
    s_nxt.alm_any = |g_alm;
    s_nxt.trip_any = !BLOCK_TRIP && (|g_trip);
    s_nxt.to_any = |g_to;
    // [R14] collective timeout
    s_nxt.to_all = (|s_r.chto) || (|g_to);
    s_nxt.vtrip = BLOCK_TRIP ? '0 : v_trip;
    // [R10] voting only when selected
    // [R15] final trip source
    if (s_r.src == SRC_VOTING) begin
      s_nxt.final_trip = !BLOCK_TRIP && (|v_trip);
    end else begin
      s_nxt.final_trip = !BLOCK_TRIP && (|e_trip);
    end
    // rising edges set sticky status, set wins over clear
    ev = 3'h0;
    ev[EV_ALM] = s_nxt.alm_any && !s_r.alm_any;
    ev[EV_TRIP] = s_nxt.final_trip && !s_r.final_trip;
    ev[EV_TO] = s_nxt.to_all && !s_r.to_all;
    s_nxt.stat = (s_r.stat & ~w1c) | ev;
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end

  // state register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_r <= '0;
      // limit and configs have their own reset words
      s_r.tolim <= TO_LIM_RST;
      s_r.cfg <= {NELEM{CFG_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign CHAN_TRIP = s_r.chtrip;
  assign CHAN_ALARM = s_r.chalm;
  assign CHAN_TIMEOUT = s_r.chto;
  assign ALARM_ANY = s_r.alm_any;
  assign TRIP_ANY = s_r.trip_any;
  assign TIMEOUT_ANY = s_r.to_any;
  assign TIMEOUT_ALARM = s_r.to_all;
  assign VOTE_TRIP = s_r.vtrip;
  assign FINAL_TRIP = s_r.final_trip;
  assign IRQ = s_r.irq;
endmodule

// >>> tcp_pkg.sv
/*
  tcp_pkg: constants, register map and helpers for the temperature
  channel protection block.
  assumes: 10 MHz system clock, APB register access, 32-bit data.
*/
package tcp_pkg;
  // channel and group layout
  localparam int TEMP_W = 12;
  localparam int NCH = 12;
  localparam int NGRP = 3;
  localparam int NELEM = NCH + NGRP;
  localparam int NVOTE = 2;
  localparam int CH_W = 4;
  localparam int CNT_W = 4;
  localparam int DLY_W = 6;
  localparam int TO_W = 8;
  // group membership: winding 0..5, ambient 6..7, auxiliary 8..11
  localparam logic [NCH-1:0] GRP_MASK [NGRP] = '{12'h03F, 12'h0C0, 12'hF00};
  // dropout ratio 0.99 as 99/100
  localparam int PROD_W = TEMP_W + 7;
  localparam logic [PROD_W-1:0] DROP_NUM = PROD_W'(8'h63);
  localparam logic [PROD_W-1:0] DROP_DEN = PROD_W'(8'h64);
  // timing
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_TO_LIM = 8'h10;
  localparam logic [7:0] REG_VOTE0 = 8'h14;
  localparam logic [7:0] REG_VOTE1 = 8'h18;
  localparam logic [7:0] CFG_BASE = 8'h20;
  localparam logic [7:0] CFG_END = 8'h5C;
  // field positions
  localparam int CTRL_ON = 0;
  localparam int CTRL_SRC = 1;
  localparam int CFG_TRIP_LO = 0;
  localparam int CFG_ALM_LO = 12;
  localparam int CFG_ON = 24;
  localparam int CFG_AEN = 25;
  localparam int CFG_DLY_LO = 26;
  localparam int VOTE_SEL_LO = 0;
  localparam int VOTE_CNT_LO = 12;
  localparam int VOTE_FN = 16;
  localparam int EV_ALM = 0;
  localparam int EV_TRIP = 1;
  localparam int EV_TO = 2;
  // reset values
  localparam logic [TO_W-1:0] TO_LIM_RST = 8'hFF;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // final trip source
  typedef enum logic {SRC_DEFAULT, SRC_VOTING} tcp_src_t;

  // strict exceedance used for pickup
  function automatic logic tcp_above(input logic [TEMP_W-1:0] t, input logic [TEMP_W-1:0] thr);
    tcp_above = t > thr;
  endfunction

  // still picked up: temperature not below 0.99 of threshold
  function automatic logic tcp_holds(input logic [TEMP_W-1:0] t, input logic [TEMP_W-1:0] thr);
    tcp_holds = (PROD_W'(t) * DROP_DEN) >= (PROD_W'(thr) * DROP_NUM);
  endfunction
endpackage

// >>> tcp_elem.sv
/*
  tcp_elem: one threshold element, an undelayed trip and a delayed
  alarm, both with 0.99 dropout.
  assumes: tick is a one-cycle pulse from the top prescaler.
*/
`timescale 1ns/100ps
module tcp_elem
  import tcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic en,
  input wire logic alarm_en,
  input wire logic [TEMP_W-1:0] temp,
  input wire logic [TEMP_W-1:0] trip_thr,
  input wire logic [TEMP_W-1:0] alm_thr,
  input wire logic [DLY_W-1:0] alm_dly,
  output logic trip,
  output logic alarm
);
  // element state
  typedef struct packed {
    logic trip;
    logic alarm;
    logic [DLY_W-1:0] cnt;
  } tcp_elem_t;
  tcp_elem_t s_r, s_nxt;
  logic acond; // alarm condition with dropout

  // next state
  always_comb begin
    s_nxt = s_r;
    // [R1] trip without delay
    // [R3] trip drops below 0.99
    s_nxt.trip = en && (s_r.trip ? tcp_holds(temp, trip_thr) : tcp_above(temp, trip_thr));
    // [R2] alarm enabled per element
    // [R3] alarm drops below 0.99
    acond = en && alarm_en && (s_r.alarm ? tcp_holds(temp, alm_thr) : tcp_above(temp, alm_thr));
    if (!acond) begin
      // [R17] timer restarts on dropout
      s_nxt.alarm = 1'b0;
      s_nxt.cnt = '0;
    end else if (!s_r.alarm && tick) begin
      // delay counted in ticks
      if (s_r.cnt >= alm_dly) begin
        s_nxt.alarm = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign trip = s_r.trip;
  assign alarm = s_r.alarm;
endmodule

// >>> tcp_vote.sv
/*
  tcp_vote: one N-of-selected voting scheme.
  assumes: hit carries the per-channel trip pickups, sel is already
  gated by channel and function activity.
*/
`timescale 1ns/100ps
module tcp_vote
  import tcp_pkg::*;
#(
  parameter int N = NCH
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fn_on,
  input wire logic [N-1:0] sel,
  input wire logic [N-1:0] hit,
  input wire logic [CNT_W-1:0] need,
  output logic trip
);
  // scheme state
  typedef struct packed {
    logic trip;
  } tcp_vote_t;
  tcp_vote_t s_r, s_nxt;

  // count of set bits
  function automatic logic [CNT_W:0] popcnt(input logic [N-1:0] v);
    popcnt = '0;
    for (int i = 0; i < N; i++) begin
      popcnt = popcnt + (CNT_W + 1)'(v[i]);
    end
  endfunction

  // next state
  always_comb begin
    s_nxt = s_r;
    // [R7] only with function on
    // [R8] count reaches programmed vote
    s_nxt.trip = fn_on && (need != '0) && (popcnt(sel & hit) >= {1'b0, need});
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign trip = s_r.trip;
endmodule

// >>> tcp_asserts.sv
/*
  tcp_asserts: port checker for tcp_top, bound below.
  assumes: one CLK domain with synchronous active-low RST_N.
*/
`timescale 1ns/100ps
module tcp_asserts
  import tcp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic BLOCK_TRIP,
  input wire logic [NCH-1:0] CHAN_TRIP,
  input wire logic [NCH-1:0] CHAN_ALARM,
  input wire logic [NCH-1:0] CHAN_TIMEOUT,
  input wire logic ALARM_ANY,
  input wire logic TRIP_ANY,
  input wire logic TIMEOUT_ANY,
  input wire logic TIMEOUT_ALARM,
  input wire logic [NVOTE-1:0] VOTE_TRIP,
  input wire logic FINAL_TRIP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // apb phases
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  a_ready_zero_wait: assert property (s_setup ##1 s_access |-> PREADY)
    else $error("ready missing in first access cycle");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held past one cycle");
  a_err_decode: assert property (PSEL && PENABLE && PREADY && PADDR[1:0] == 2'h0
    |-> PSLVERR == (PADDR == 8'h1C || PADDR >= CFG_END))
    else $error("error response does not match address map");
  a_err_data: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
    else $error("refused access returned data");
  a_block_chan: assert property (BLOCK_TRIP [*3] |-> CHAN_TRIP == '0 && VOTE_TRIP == '0 && !TRIP_ANY)
    else $error("trip seen while blocked");
  a_block_final: assert property (BLOCK_TRIP [*3] |-> !FINAL_TRIP)
    else $error("final trip seen while blocked");
  a_trip_collect: assert property (CHAN_TRIP != '0 |-> TRIP_ANY)
    else $error("channel trip missing from any-group trip");
  a_alarm_collect: assert property (CHAN_ALARM != '0 |-> ALARM_ANY)
    else $error("channel alarm missing from any-group alarm");
  a_timeout_coll: assert property (CHAN_TIMEOUT != '0 |=> TIMEOUT_ALARM)
    else $error("channel timeout missing from collective timeout");
  a_timeout_group: assert property (TIMEOUT_ANY |-> TIMEOUT_ALARM)
    else $error("group timeout missing from collective timeout");
  a_final_source: assert property (FINAL_TRIP |-> TRIP_ANY || VOTE_TRIP != '0
    || $past(TRIP_ANY) || $past(VOTE_TRIP) != '0)
    else $error("final trip without a source");
endmodule

bind tcp_top tcp_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.CLK(CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .BLOCK_TRIP(BLOCK_TRIP), .CHAN_TRIP(CHAN_TRIP), .CHAN_ALARM(CHAN_ALARM),
  .CHAN_TIMEOUT(CHAN_TIMEOUT), .ALARM_ANY(ALARM_ANY), .TRIP_ANY(TRIP_ANY),
  .TIMEOUT_ANY(TIMEOUT_ANY), .TIMEOUT_ALARM(TIMEOUT_ALARM), .VOTE_TRIP(VOTE_TRIP),
  .FINAL_TRIP(FINAL_TRIP));

// >>> tcp_rtd_model.sv
/*
  tcp_rtd_model: stands in for the remote temperature interface.
  assumes: runs on the bench clock; one update per call.
*/
`timescale 1ns/100ps
module tcp_rtd_model
  import tcp_pkg::*;
(
  input wire logic clk,
  output logic upd,
  output logic [CH_W-1:0] ch,
  output logic [TEMP_W-1:0] val
);
  // idle: no strobe, lines scrambled
  initial begin
    upd = 1'b0;
    ch = 4'hF;
    val = 12'hA5A;
  end

  // one strobe, then stale lines inverted so they never look valid
  task automatic send(input logic [CH_W-1:0] c, input logic [TEMP_W-1:0] v);
    @(posedge clk);
    upd <= 1'b1;
    ch <= c;
    val <= v;
    @(posedge clk);
    upd <= 1'b0;
    ch <= ~c;
    val <= ~v;
  endtask
endmodule

// >>> tcp_tb.sv
/*
  testbench: drives tcp_top over APB and through the sensor model.
  assumes: tcp_pkg compiled first; tick shortened to 4 cycles.
*/
`timescale 1ns/100ps
module testbench
  import tcp_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, block_trip, upd, rd_e;
  logic alarm_any, trip_any, timeout_any, timeout_alarm, final_trip, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [CH_W-1:0] ch;
  logic [TEMP_W-1:0] val;
  logic [NCH-1:0] chan_trip, chan_alarm, chan_timeout;
  logic [NVOTE-1:0] vote_trip;
  int mismatches, num_checks, cycles;

  tcp_top #(.TICK_CYCLES(4)) dut_u (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TEMP_UPD(upd), .TEMP_CH(ch), .TEMP_VAL(val),
    .BLOCK_TRIP(block_trip), .CHAN_TRIP(chan_trip), .CHAN_ALARM(chan_alarm),
    .CHAN_TIMEOUT(chan_timeout), .ALARM_ANY(alarm_any), .TRIP_ANY(trip_any),
    .TIMEOUT_ANY(timeout_any), .TIMEOUT_ALARM(timeout_alarm), .VOTE_TRIP(vote_trip),
    .FINAL_TRIP(final_trip), .IRQ(irq));
  tcp_rtd_model model_u (.clk(clk), .upd(upd), .ch(ch), .val(val));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd_q);
  endtask

  // channel or group config word
  task automatic cfg(input int k, input logic [11:0] tr, input logic [11:0] al,
                     input logic on, input logic aen, input logic [5:0] dly);
    wr(8'h20 + 8'(4 * k), {dly, aen, on, al, tr});
  endtask

  // settle after n edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 6000) begin
        mismatches++;
        print_verdict;
      end
    end
  end

  initial begin
    {rst_n, psel, penable, pwrite, block_trip} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc("ctrl", REG_CTRL, 32'h0);
    rdc("to_lim", REG_TO_LIM, 32'hFF);
    rdc("mask", REG_IRQ_MASK, 32'h0);
    rdc("vote0", REG_VOTE0, 32'h0);
    rdc("cfg5", 8'h34, CFG_RST);
    apb(1'b0, 8'h1C, 32'h0);
    chk("hole_err", 32'h1, rd_e);
    wr(REG_STATUS, 32'hFFFFFFFF);
    rdc("status_ro", REG_STATUS, 32'h0);
    rdc("cfg9_kept", 8'h44, CFG_RST);
    $display("test regs done");
    wr(REG_CTRL, 32'h1);
    cfg(0, 12'h064, 12'hFFF, 1'b1, 1'b0, 6'h0);
    cfg(4, 12'hFFF, 12'h010, 1'b1, 1'b0, 6'h0);
    cfg(12, 12'h0C8, 12'hFFF, 1'b1, 1'b0, 6'h0);
    model_u.send(4'h0, 12'h064);
    cyc(3);
    chk("pick_equal", 32'h0, chan_trip[0]);
    model_u.send(4'h0, 12'h065);
    cyc(2);
    chk("trip_fast", 32'h1, chan_trip[0]);
    chk("final_def", 32'h1, final_trip);
    model_u.send(4'h0, 12'h063);
    cyc(3);
    chk("hold_99", 32'h1, chan_trip[0]);
    model_u.send(4'h0, 12'h062);
    cyc(3);
    chk("drop_98", 32'h0, chan_trip[0]);
    model_u.send(4'h4, 12'h0FA);
    cyc(3);
    chk("grp_chan", 32'h0, chan_trip[4]);
    chk("grp_trip", 32'h1, trip_any);
    @(posedge clk);
    block_trip <= 1'b1;
    cyc(3);
    chk("blk_any", 32'h0, trip_any);
    chk("blk_final", 32'h0, final_trip);
    @(posedge clk);
    block_trip <= 1'b0;
    model_u.send(4'h4, 12'h020);
    model_u.send(4'h0, 12'h200);
    wr(REG_CTRL, 32'h0);
    cyc(3);
    chk("fn_off", 32'h0, chan_trip[0]);
    wr(REG_CTRL, 32'h1);
    cyc(3);
    chk("fn_on", 32'h1, chan_trip[0]);
    cfg(0, 12'h064, 12'hFFF, 1'b0, 1'b0, 6'h0);
    cyc(3);
    chk("ch_off", 32'h0, chan_trip[0]);
    $display("test trip done");
    cfg(1, 12'hFFF, 12'h032, 1'b1, 1'b1, 6'h2);
    wr(REG_IRQ_STAT, 32'h7);
    wr(REG_IRQ_MASK, 32'h1);
    model_u.send(4'h1, 12'h03C);
    cyc(6);
    model_u.send(4'h1, 12'h028);
    model_u.send(4'h1, 12'h03C);
    cyc(5);
    chk("alm_restart", 32'h0, chan_alarm[1]);
    chk("irq_quiet", 32'h0, irq);
    for (int i = 0; i < 40 && chan_alarm[1] !== 1'b1; i++) cyc(1);
    chk("alm_set", 32'h1, chan_alarm[1]);
    chk("alm_any", 32'h1, alarm_any);
    chk("alm_dis", 32'h0, chan_alarm[4]);
    cyc(2);
    chk("irq_set", 32'h1, irq);
    wr(REG_IRQ_MASK, 32'h0);
    cyc(2);
    chk("irq_mask", 32'h0, irq);
    wr(REG_IRQ_MASK, 32'h1);
    cyc(2);
    chk("irq_unmask", 32'h1, irq);
    wr(REG_IRQ_STAT, 32'h1);
    cyc(2);
    chk("irq_clear", 32'h0, irq);
    model_u.send(4'h1, 12'h031);
    cyc(3);
    chk("alm_drop", 32'h0, chan_alarm[1]);
    $display("test alarm done");
    cfg(2, 12'h064, 12'hFFF, 1'b1, 1'b0, 6'h0);
    cfg(3, 12'h064, 12'hFFF, 1'b1, 1'b0, 6'h0);
    model_u.send(4'h2, 12'h096);
    model_u.send(4'h3, 12'h096);
    wr(REG_CTRL, 32'h3);
    wr(REG_VOTE0, {15'h0, 1'b0, 4'h2, 12'h00C});
    cyc(3);
    chk("vote_fn_off", 32'h0, vote_trip);
    chk("final_vote", 32'h0, final_trip);
    wr(REG_VOTE0, {15'h0, 1'b1, 4'h2, 12'h00C});
    cyc(3);
    chk("vote_two", 32'h1, vote_trip);
    chk("final_on", 32'h1, final_trip);
    wr(REG_VOTE0, {15'h0, 1'b1, 4'h3, 12'h00C});
    cyc(3);
    chk("vote_three", 32'h0, vote_trip);
    wr(REG_VOTE0, {15'h0, 1'b1, 4'h2, 12'h00C});
    cfg(3, 12'h064, 12'hFFF, 1'b0, 1'b0, 6'h0);
    wr(REG_VOTE1, {15'h0, 1'b1, 4'h1, 12'h004});
    cyc(3);
    chk("vote_sel", 32'h2, vote_trip);
    wr(REG_CTRL, 32'h1);
    cyc(3);
    chk("final_dflt", 32'h1, final_trip);
    $display("test vote done");
    wr(REG_TO_LIM, 32'h3);
    for (int i = 0; i < 60 && timeout_alarm !== 1'b1; i++) cyc(1);
    chk("to_alarm", 32'h1, timeout_alarm);
    chk("to_chan", 32'h1, chan_timeout[1]);
    chk("to_group", 32'h1, timeout_any);
    chk("to_off", 32'h0, chan_timeout[0]);
    rdc("status_to", REG_STATUS, 32'h0006_E016);
    model_u.send(4'h1, 12'h000);
    cyc(2);
    chk("to_clear", 32'h0, chan_timeout[1]);
    $display("test timeout done");
    print_verdict;
  end
endmodule
